// File: rtl/tdc_io_and_serial_readout.sv
// tdc pin front end: hit gating, index counter, per-channel fifos,
// serial result outputs and the serial configuration port pins
// assumes all pins are asynchronous to core_clk and are slow next to it
`timescale 1ns/1ps
`default_nettype none
`include "tdc_io_regs.svh"

// result buffer; depth must be a power of two so pointers wrap naturally
module result_fifo #(
   parameter int W = 48,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   // pointer and fill level update
   always_comb begin
      in_ready = (cnt_q != (AW+1)'(DEPTH));
      out_valid = (cnt_q != '0);
      push = in_valid & in_ready;
      pop = out_valid & out_ready;
      wr_d = push ? wr_q + AW'(1) : wr_q;
      rd_d = pop ? rd_q + AW'(1) : rd_q;
      cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      out_data = mem_q[rd_q];
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // storage has no reset; empty level hides stale words
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule : result_fifo

module tdc_io_and_serial_readout
   import tdc_io_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter int CFG_BITS = 144
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // measurement pins
   input wire logic ref_clock_in,
   input wire logic index_clear_in,
   input wire logic hit_block_in,
   input wire logic [3:0] hit_inputs,
   // configuration bits
   input wire logic input_single_ended,
   input wire logic [3:0] buffer_enables,
   input wire logic index_clear_buffer_en,
   input wire logic hit_block_buffer_en,
   input wire logic [3:0] channel_soft_enables,
   input wire logic [1:0] channel_pairing,
   input wire logic serial_output_enable,
   input wire logic double_rate,
   input wire logic test_pattern,
   input wire logic [4:0] index_field_width,
   input wire logic [4:0] result_field_width,
   input wire logic [1:0] output_delay_trim,
   input wire logic [CFG_BITS-1:0] config_bits,
   // serial result link
   input wire logic link_clock_in,
   output logic link_clock_out,
   output logic [3:0] serial_result_out,
   output logic [3:0] frame_out,
   output logic [3:0] serial_driver_en,
   // serial configuration port
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic slave_select_n,
   output logic miso_out,
   output logic miso_oe,
   // status pins
   output logic irq_n,
   output logic parity_out,
   output logic level_select_out
);
   // low-order mask of a field, width already clamped
   function automatic logic [23:0] field_mask(input logic [5:0] w);
      field_mask = 24'hffffff >> (`FIELD_MAX - w);
   endfunction : field_mask

   // field width limited to 1..24
   function automatic logic [5:0] clamp_w(input logic [4:0] w);
      if (w == 5'h00) clamp_w = 6'h01;
      else if ({1'b0, w} > `FIELD_MAX) clamp_w = `FIELD_MAX;
      else clamp_w = {1'b0, w};
   endfunction : clamp_w

   pair_mode_e pm;
   assign pm = pair_mode_e'(channel_pairing);

   // two-stage synchronisers plus one history stage for edge finding
   logic [`SYN_W-1:0] pins, s1_q, s2_q, s3_q;
   assign pins = {sck_in, mosi_in, slave_select_n, link_clock_in, ref_clock_in,
                  index_clear_in, hit_block_in, hit_inputs};
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s1_q <= `SYN_RESET;
         s2_q <= `SYN_RESET;
         s3_q <= `SYN_RESET;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   logic ref_rise, lrise, lfall, sck_rise, sck_fall, ssn_hi, blocked;
   logic [3:0] hit_rise, hit_fall;
   always_comb begin
      ref_rise = s2_q[`SYN_REF] & ~s3_q[`SYN_REF];
      lrise = s2_q[`SYN_LCLK] & ~s3_q[`SYN_LCLK];
      lfall = ~s2_q[`SYN_LCLK] & s3_q[`SYN_LCLK];
      sck_rise = s2_q[`SYN_SCK] & ~s3_q[`SYN_SCK];
      sck_fall = ~s2_q[`SYN_SCK] & s3_q[`SYN_SCK];
      ssn_hi = s2_q[`SYN_SSN];
      hit_rise = s2_q[`SYN_HIT+:4] & ~s3_q[`SYN_HIT+:4];
      hit_fall = ~s2_q[`SYN_HIT+:4] & s3_q[`SYN_HIT+:4];
      blocked = hit_block_buffer_en & s2_q[`SYN_BLOCK];
   end

   // period index and time since last reference edge
   logic [23:0] index_q, index_d, fine_q, fine_d;
   always_comb begin
      index_d = index_q;
      fine_d = (fine_q == 24'hffffff) ? fine_q : fine_q + 24'h000001;
      if (ref_rise) begin
         fine_d = 24'h000000;
         if (index_clear_buffer_en & s2_q[`SYN_IDXCLR]) index_d = 24'h000000;
         else index_d = index_q + 24'h000001;
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         index_q <= 24'h000000;
         fine_q <= 24'h000000;
      end else begin
         index_q <= index_d;
         fine_q <= fine_d;
      end
   end

   // hit routing into channels; reference counting never stops here
   logic [1:0] toggle_q, toggle_d;
   logic [3:0] gate, ev, push, fifo_ready, fifo_valid, tx_pop, spi_pop;
   result_t fifo_dout [4];
   always_comb begin
      toggle_d = toggle_q;
      gate = buffer_enables & {4{~blocked & ~test_pattern}};
      ev = hit_rise & gate;
      for (int i = 0; i < 2; i++) begin
         if (pm == PAIR_SPACING) begin
            ev[i] = hit_rise[i] & gate[i] & ~toggle_q[i];
            ev[i+2] = hit_rise[i] & gate[i] & toggle_q[i];
            if (hit_rise[i] & gate[i]) toggle_d[i] = ~toggle_q[i];
         end else if (pm == PAIR_WIDTH) begin
            ev[i+2] = hit_fall[i] & gate[i];
         end
      end
      push = ev & channel_soft_enables & fifo_ready;
   end
   always_ff @(posedge core_clk) begin
      if (srst) toggle_q <= 2'b00;
      else toggle_q <= toggle_d;
   end

   // one result buffer per channel; a hit into a full buffer is dropped
   for (genvar g = 0; g < 4; g++) begin : g_fifo
      result_fifo #(.W(48), .DEPTH(FIFO_DEPTH)) u_fifo (
         .core_clk(core_clk),
         .srst(srst),
         .in_valid(ev[g] & channel_soft_enables[g]),
         .in_ready(fifo_ready[g]),
         .in_data({index_q, fine_q}),
         .out_valid(fifo_valid[g]),
         .out_ready(tx_pop[g] | spi_pop[g]),
         .out_data(fifo_dout[g])
      );
   end

   // serial transmitters; left_q counts bits still to send
   logic upd;
   logic [5:0] iw, rw;
   logic [3:0] src_valid, start, data_q, data_d, frame_q, frame_d;
   logic [5:0] left_q [4];
   logic [5:0] left_d [4];
   logic [5:0] total_q [4];
   logic [5:0] total_d [4];
   result_t word_q [4];
   result_t word_d [4];
   result_t src;
   always_comb begin
      upd = double_rate ? (lrise | lfall) : lfall;
      iw = clamp_w(index_field_width);
      rw = clamp_w(result_field_width);
      src = '0;
      for (int c = 0; c < 4; c++) begin
         src_valid[c] = test_pattern | fifo_valid[c];
         start[c] = upd & (left_q[c] == 6'd0) & serial_output_enable & buffer_enables[c] & src_valid[c]
                    & ((pm == PAIR_NONE) | src_valid[c^2]);
         tx_pop[c] = start[c] & ~test_pattern;
         left_d[c] = left_q[c];
         total_d[c] = total_q[c];
         word_d[c] = word_q[c];
         data_d[c] = data_q[c];
         frame_d[c] = frame_q[c];
         src = test_pattern ? {`TEST_INDEX, `TEST_RESULT} : fifo_dout[c];
         if (!serial_output_enable) begin
            left_d[c] = 6'd0;
            data_d[c] = 1'b0;
            frame_d[c] = 1'b0;
         end else if (upd) begin
            if (left_q[c] != 6'd0) begin
               data_d[c] = word_q[c][left_q[c]-6'd1];
               frame_d[c] = (total_q[c] - left_q[c]) < `FRAME_BITS;
               left_d[c] = left_q[c] - 6'd1;
            end else if (start[c]) begin
               word_d[c] = ({24'h000000, src[47:24] & field_mask(iw)} << rw) | {24'h000000, src[23:0] & field_mask(rw)};
               total_d[c] = iw + rw;
               data_d[c] = word_d[c][total_d[c]-6'd1];
               frame_d[c] = 1'b1;
               left_d[c] = total_d[c] - 6'd1;
            end else begin
               data_d[c] = 1'b0;
               frame_d[c] = 1'b0;
            end
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         data_q <= 4'h0;
         frame_q <= 4'h0;
         for (int c = 0; c < 4; c++) begin
            left_q[c] <= 6'd0;
            total_q[c] <= 6'd0;
            word_q[c] <= '0;
         end
      end else begin
         data_q <= data_d;
         frame_q <= frame_d;
         for (int c = 0; c < 4; c++) begin
            left_q[c] <= left_d[c];
            total_q[c] <= total_d[c];
            word_q[c] <= word_d[c];
         end
      end
   end

   // output stage; trim delays data and frame alike, in double rate only, for hold margin
   logic [2:0] dly_q [4];
   logic [2:0] dly_d [4];
   logic [2:0] fdly_q [4];
   logic [2:0] fdly_d [4];
   logic [3:0] sdo_d, frm_d;
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         dly_d[c] = {dly_q[c][1:0], data_q[c]};
         fdly_d[c] = {fdly_q[c][1:0], frame_q[c]};
         sdo_d[c] = data_q[c];
         frm_d[c] = frame_q[c];
         if (double_rate && output_delay_trim != 2'b00) begin
            sdo_d[c] = dly_q[c][output_delay_trim-2'b01];
            frm_d[c] = fdly_q[c][output_delay_trim-2'b01];
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         for (int c = 0; c < 4; c++) begin
            dly_q[c] <= 3'b000;
            fdly_q[c] <= 3'b000;
         end
         link_clock_out <= 1'b0;
         serial_result_out <= 4'h0;
         frame_out <= 4'h0;
         serial_driver_en <= 4'h0;
         irq_n <= 1'b1;
         parity_out <= 1'b0;
         level_select_out <= 1'b0;
      end else begin
         for (int c = 0; c < 4; c++) begin
            dly_q[c] <= dly_d[c];
            fdly_q[c] <= fdly_d[c];
         end
         link_clock_out <= s3_q[`SYN_LCLK];
         serial_result_out <= sdo_d;
         frame_out <= frm_d;
         serial_driver_en <= buffer_enables & {4{serial_output_enable}};
         irq_n <= ~|fifo_valid;
         parity_out <= ^config_bits;
         level_select_out <= input_single_ended;
      end
   end

   // serial port: first byte picks a channel, then 48 bits of its result, or all ones if it is empty or serial output is enabled
   spi_state_e st_q, st_d;
   logic [7:0] rx_q, rx_d;
   logic [3:0] bit_q, bit_d;
   logic [5:0] txn_q, txn_d;
   result_t tx_q, tx_d;
   logic [1:0] spi_ch;
   logic spi_load, miso_d;
   always_comb begin
      st_d = st_q;
      rx_d = rx_q;
      bit_d = bit_q;
      txn_d = txn_q;
      tx_d = tx_q;
      miso_d = miso_out;
      spi_ch = {rx_q[0], s2_q[`SYN_MOSI]};
      spi_load = 1'b0;
      spi_pop = 4'h0;
      if (ssn_hi) begin
         st_d = SPI_CMD;
         bit_d = 4'd0;
         txn_d = 6'd0;
         miso_d = 1'b0;
      end else begin
         case (st_q)
            SPI_CMD: begin
               if (sck_fall) begin
                  rx_d = {rx_q[6:0], s2_q[`SYN_MOSI]};
                  bit_d = bit_q + 4'd1;
                  if (bit_q == `SPI_CMD_LAST) begin
                     spi_load = 1'b1;
                     st_d = SPI_SEND;
                     txn_d = `SPI_WORD_BITS;
                     tx_d = (fifo_valid[spi_ch] & ~serial_output_enable) ? fifo_dout[spi_ch]
                            : {`EMPTY_FIELD, `EMPTY_FIELD};
                     spi_pop[spi_ch] = fifo_valid[spi_ch] & ~serial_output_enable;
                  end
               end
            end
            SPI_SEND: begin
               if (sck_rise && txn_q != 6'd0) begin
                  miso_d = tx_q[txn_q-6'd1];
                  txn_d = txn_q - 6'd1;
               end
            end
            default: st_d = SPI_CMD;
         endcase
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_q <= SPI_CMD;
         rx_q <= 8'h00;
         bit_q <= 4'd0;
         txn_q <= 6'd0;
         tx_q <= '0;
         miso_out <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         st_q <= st_d;
         rx_q <= rx_d;
         bit_q <= bit_d;
         txn_q <= txn_d;
         tx_q <= tx_d;
         miso_out <= miso_d;
         miso_oe <= ~ssn_hi;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   AST_INDEX_CLEAR: assert property (ref_rise && index_clear_buffer_en && s2_q[`SYN_IDXCLR] |=> index_q == 24'h0)
      else $error("index not cleared");
   AST_INDEX_COUNT: assert property (ref_rise && !index_clear_buffer_en |=> index_q == $past(index_q) + 24'h1)
      else $error("index did not advance");
   AST_BLOCKED: assert property (blocked |-> push == 4'h0)
      else $error("hit taken while blocked");
   AST_SOFT_EN: assert property ((push & ~channel_soft_enables) == 4'h0)
      else $error("hit on soft-disabled channel");
   AST_TEST_NO_HIT: assert property (test_pattern |-> push == 4'h0)
      else $error("hit taken in test pattern");
   AST_FRAME_START: assert property (start[0] |=> frame_q[0] && left_q[0] == total_q[0] - 6'd1)
      else $error("sequence start without frame");
   AST_IDLE_NO_FRAME: assert property (upd && left_q[0] == 6'd0 && !start[0] |=> !frame_q[0])
      else $error("frame while idle");
   AST_SDR_FALL_ONLY: assert property (serial_output_enable && !double_rate && !lfall && !$past(double_rate)
                                       |=> $stable(data_q))
      else $error("single rate data moved off falling edge");
   AST_MISO_RELEASE: assert property (ssn_hi |=> !miso_oe)
      else $error("data output driven while deselected");
   AST_IRQ_LOW: assert property ((|fifo_valid) |=> !irq_n)
      else $error("interrupt not low with data");
   AST_PARITY: assert property (1'b1 |=> parity_out == ^$past(config_bits))
      else $error("parity mismatch");
   AST_EMPTY_READ: assert property (spi_load && !fifo_valid[spi_ch] |=> tx_q == 48'hffffffffffff)
      else $error("empty read not all ones");

   COV_HIT_PUSH: cover property (push[0] ##1 fifo_valid[0]);
   COV_SEQ_DONE: cover property (start[0] ##[1:200] (upd && left_q[0] == 6'd0));
   COV_SPI_READ: cover property (spi_load && fifo_valid[spi_ch]);
   COV_PAIR: cover property (pm == PAIR_SPACING && push[2]);
endmodule : tdc_io_and_serial_readout
`default_nettype wire

// File: rtl/tdc_io_pkg.sv
// types shared by the tdc pin front end and serial result readout
// assumes nothing beyond the constants header
`default_nettype none
package tdc_io_pkg;
   typedef enum logic [1:0] {
      PAIR_NONE = 2'b00,
      PAIR_SPACING = 2'b01,
      PAIR_WIDTH = 2'b10
   } pair_mode_e;
   typedef enum logic {
      SPI_CMD = 1'b0,
      SPI_SEND = 1'b1
   } spi_state_e;
   typedef logic [47:0] result_t;
endpackage : tdc_io_pkg
`default_nettype wire

// File: rtl/tdc_io_regs.svh
// constants for the tdc pin front end and serial result readout
// assumes inclusion by bare name from the design file
`ifndef TDC_IO_REGS_SVH
`define TDC_IO_REGS_SVH
// positions in the synchronised pin vector
`define SYN_HIT 0
`define SYN_BLOCK 4
`define SYN_IDXCLR 5
`define SYN_REF 6
`define SYN_LCLK 7
`define SYN_SSN 8
`define SYN_MOSI 9
`define SYN_SCK 10
`define SYN_W 11
// reset value of the synchroniser: slave select idles high
`define SYN_RESET 11'h100
// fixed test pattern and empty-channel marker
`define TEST_INDEX 24'hf0ccaa
`define TEST_RESULT 24'h0aacf0
`define EMPTY_FIELD 24'hffffff
// framing and field limits
`define FRAME_BITS 6'd8
`define FIELD_MAX 6'd24
`define FIELD_W 24
// serial port byte and word lengths
`define SPI_CMD_LAST 4'd7
`define SPI_WORD_BITS 6'd48
`endif

// File: sim/link_receiver_model.sv
// far-side receiver model: makes the link clock and gathers channel 0 words
// assumes data and frame are settled at each sampling edge of the looped clock
`timescale 1ns/1ps
`default_nettype none
module link_receiver_model (
   // control from the bench
   input wire logic run,
   input wire logic ddr,
   // link pins
   output var logic link_clock_in,
   input wire logic link_clock_out,
   input wire logic sdata,
   input wire logic frame,
   // gathered word
   output var logic [47:0] word,
   output var logic [5:0] bits,
   output var logic [5:0] frame_bits
);
   logic frame_prev;
   // clock stands still low outside traffic; odd offset keeps it unrelated to core_clk
   initial begin
      link_clock_in = 1'b0;
      #3;
      forever #40 link_clock_in = run ? ~link_clock_in : 1'b0;
   end
   // counters start at a rising frame only, so idle bits never look like a word
   initial begin
      word = 48'h0;
      bits = 6'h00;
      frame_bits = 6'h00;
      frame_prev = 1'b0;
   end
   // single rate samples rising edges only; double rate samples both, relying on the trim for hold
   always @(link_clock_out) begin
      if (ddr || link_clock_out) begin
         if (frame && !frame_prev) begin
            word <= {47'h0, sdata};
            bits <= 6'h01;
            frame_bits <= 6'h01;
         end else if (bits != 6'h00) begin
            word <= {word[46:0], sdata};
            bits <= bits + 6'h01;
            frame_bits <= frame_bits + {5'h00, frame};
         end
         frame_prev <= frame;
      end
   end
endmodule : link_receiver_model
`default_nettype wire

// File: sim/tdc_io_and_serial_readout_test.sv
// self-checking bench for the tdc pin front end and serial result readout
// assumes the design files and the receiver model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module tdc_io_and_serial_readout_test;
   import tdc_io_pkg::*;
   logic core_clk, srst, ref_clock_in, index_clear_in, hit_block_in, input_single_ended;
   logic index_clear_buffer_en, hit_block_buffer_en, serial_output_enable, double_rate;
   logic test_pattern, link_clock_in, link_clock_out, sck_in, mosi_in, slave_select_n;
   logic miso_out, miso_oe, irq_n, parity_out, level_select_out, run;
   logic [3:0] hit_inputs, buffer_enables, channel_soft_enables, serial_result_out;
   logic [3:0] frame_out, serial_driver_en;
   logic [1:0] channel_pairing, output_delay_trim;
   logic [4:0] index_field_width, result_field_width;
   logic [143:0] config_bits;
   logic [47:0] rx_word, rd;
   logic [5:0] rx_bits, rx_frame_bits;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   tdc_io_and_serial_readout #(.FIFO_DEPTH(16), .CFG_BITS(144)) dut (.core_clk(core_clk), .srst(srst),
      .ref_clock_in(ref_clock_in), .index_clear_in(index_clear_in), .hit_block_in(hit_block_in),
      .hit_inputs(hit_inputs), .input_single_ended(input_single_ended), .buffer_enables(buffer_enables),
      .index_clear_buffer_en(index_clear_buffer_en), .hit_block_buffer_en(hit_block_buffer_en),
      .channel_soft_enables(channel_soft_enables), .channel_pairing(channel_pairing),
      .serial_output_enable(serial_output_enable), .double_rate(double_rate), .test_pattern(test_pattern),
      .index_field_width(index_field_width), .result_field_width(result_field_width),
      .output_delay_trim(output_delay_trim), .config_bits(config_bits), .link_clock_in(link_clock_in),
      .link_clock_out(link_clock_out), .serial_result_out(serial_result_out), .frame_out(frame_out),
      .serial_driver_en(serial_driver_en), .sck_in(sck_in), .mosi_in(mosi_in),
      .slave_select_n(slave_select_n), .miso_out(miso_out), .miso_oe(miso_oe), .irq_n(irq_n),
      .parity_out(parity_out), .level_select_out(level_select_out));
   link_receiver_model rx (.run(run), .ddr(double_rate), .link_clock_in(link_clock_in),
      .link_clock_out(link_clock_out),
      .sdata(serial_result_out[0]), .frame(frame_out[0]), .word(rx_word), .bits(rx_bits),
      .frame_bits(rx_frame_bits));
   // 100 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   // a hang counts as a mismatch; the whole run needs well under 20000 cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic ticks(input int n);
      repeat (n) @(posedge core_clk);
   endtask : ticks
   // pins hold each level well beyond the two-flop synchroniser
   task automatic hit(input int ch);
      hit_inputs[ch] <= 1'b1;
      ticks(4);
      hit_inputs[ch] <= 1'b0;
      ticks(6);
   endtask : hit
   // clear is held from two cycles before the reference rise until four cycles after its fall
   task automatic ref_period(input logic clr);
      index_clear_in <= clr;
      ticks(2);
      ref_clock_in <= 1'b1;
      ticks(4);
      ref_clock_in <= 1'b0;
      ticks(4);
      index_clear_in <= 1'b0;
      ticks(2);
   endtask : ref_period
   // mode 0-1 master: select pulse first, clock idles low, mosi read on falling edges
   task automatic spi_read(input logic [1:0] ch, output logic [47:0] data);
      logic [7:0] cmd;
      cmd = {6'h00, ch};
      slave_select_n <= 1'b1;
      ticks(6);
      slave_select_n <= 1'b0;
      ticks(6);
      for (int i = 0; i < 56; i++) begin
         mosi_in <= (i < 8) ? cmd[7-i] : 1'b0;
         sck_in <= 1'b1;
         ticks(6);
         if (i >= 8) data = {data[46:0], miso_out};
         sck_in <= 1'b0;
         ticks(6);
      end
      `CHK("miso_oe selected", 1'b1, miso_oe)
      slave_select_n <= 1'b1;
      ticks(6);
      `CHK("miso_oe deselected", 1'b0, miso_oe)
   endtask : spi_read
   task automatic t_reset_state;
      `CHK("irq_n idle", 1'b1, irq_n)
      `CHK("frame idle", 4'h0, frame_out)
      $display("test reset_state done");
   endtask : t_reset_state
   task automatic t_status;
      config_bits <= 144'h1;
      input_single_ended <= 1'b1;
      ticks(3);
      `CHK("parity odd", 1'b1, parity_out)
      `CHK("level single", 1'b1, level_select_out)
      config_bits <= {1'b1, 142'h0, 1'b1};
      input_single_ended <= 1'b0;
      ticks(3);
      `CHK("parity even", 1'b0, parity_out)
      `CHK("level diff", 1'b0, level_select_out)
      $display("test status done");
   endtask : t_status
   task automatic t_link;
      logic [23:0] idx, res;
      logic seen;
      idx = 24'd15781034;
      res = 24'd699632;
      seen = 1'b0;
      serial_output_enable <= 1'b1;
      buffer_enables <= 4'h5;
      run <= 1'b1;
      // empty fifos and no pattern: nothing may be framed
      for (int k = 0; k < 200; k++) begin
         ticks(1);
         if (frame_out !== 4'h0) seen = 1'b1;
      end
      `CHK("frame while empty", 1'b0, seen)
      `CHK("driver enables", 4'h5, serial_driver_en)
      test_pattern <= 1'b1;
      for (int k = 0; k < 3000 && rx_bits !== 6'd12; k++) ticks(1);
      `CHK("sdr word length", 6'd12, rx_bits)
      `CHK("pattern word", {idx[4:0], res[6:0]}, rx_word[11:0])
      `CHK("frame bit count", 6'd8, rx_frame_bits)
      // double rate with one cycle of trim; settle past any word cut by the switch
      double_rate <= 1'b1;
      output_delay_trim <= 2'h1;
      ticks(200);
      for (int k = 0; k < 400 && rx_bits !== 6'd1; k++) ticks(1);
      for (int k = 0; k < 400 && rx_bits !== 6'd12; k++) ticks(1);
      `CHK("ddr word length", 6'd12, rx_bits)
      `CHK("ddr pattern word", {idx[4:0], res[6:0]}, rx_word[11:0])
      `CHK("ddr frame bit count", 6'd8, rx_frame_bits)
      serial_output_enable <= 1'b0;
      run <= 1'b0;
      double_rate <= 1'b0;
      output_delay_trim <= 2'h0;
      ticks(12);
      `CHK("drivers off", 4'h0, serial_driver_en)
      `CHK("data idle", 4'h0, serial_result_out)
      test_pattern <= 1'b0;
      buffer_enables <= 4'hf;
      $display("test link done");
   endtask : t_link
   task automatic t_hits;
      channel_soft_enables <= 4'h1;
      hit(1);
      ticks(4);
      `CHK("irq_n soft off", 1'b1, irq_n)
      hit_block_in <= 1'b1;
      hit_block_buffer_en <= 1'b1;
      hit(0);
      ticks(4);
      `CHK("irq_n blocked", 1'b1, irq_n)
      index_clear_buffer_en <= 1'b1;
      ref_period(1'b1);
      hit_block_buffer_en <= 1'b0;
      hit(0);
      ticks(4);
      `CHK("irq_n stored", 1'b0, irq_n)
      index_clear_buffer_en <= 1'b0;
      ref_period(1'b1);
      hit_block_in <= 1'b0;
      hit(0);
      spi_read(2'd0, rd);
      `CHK("first index", 24'h000000, rd[47:24])
      spi_read(2'd0, rd);
      `CHK("second index", 24'h000001, rd[47:24])
      spi_read(2'd0, rd);
      `CHK("empty read", 48'hffffffffffff, rd)
      `CHK("irq_n drained", 1'b1, irq_n)
      // spacing pairing: pin 0 hits alternate between channels 0 and 2
      channel_pairing <= 2'h1;
      channel_soft_enables <= 4'h5;
      hit(0);
      hit(0);
      spi_read(2'd2, rd);
      `CHK("paired lane index", 24'h000001, rd[47:24])
      spi_read(2'd0, rd);
      `CHK("home lane index", 24'h000001, rd[47:24])
      spi_read(2'd2, rd);
      `CHK("paired lane drained", 48'hffffffffffff, rd)
      channel_pairing <= 2'h0;
      $display("test hits done");
   endtask : t_hits
   initial begin
      srst = 1'b1;
      {ref_clock_in, index_clear_in, hit_block_in, input_single_ended, run} = 5'h00;
      {index_clear_buffer_en, hit_block_buffer_en, serial_output_enable, test_pattern} = 4'h0;
      {double_rate, sck_in, mosi_in, slave_select_n} = 4'h1;
      hit_inputs = 4'h0;
      buffer_enables = 4'hf;
      channel_soft_enables = 4'h0;
      channel_pairing = 2'h0;
      output_delay_trim = 2'h0;
      index_field_width = 5'h05;
      result_field_width = 5'h07;
      config_bits = 144'h0;
      ticks(8);
      srst <= 1'b0;
      ticks(4);
      t_reset_state();
      t_status();
      t_link();
      t_hits();
      give_verdict();
   end
endmodule : tdc_io_and_serial_readout_test
`default_nettype wire
